//--- verilog/dsr_top.sv
`timescale 1ns/1ps
`include "dsr_defs.svh"

// Contract
// - stagger groups delayed unless stagger disabled
// - stagger disable is cfg 0x08 bit 3
// - local control low disables control channel
// - straps captured once at power-up
// - straps choose input, width, sync encoding
// - receive strap enables error correction
// - transmit strap selects output valid edge
// - negative wire fault code at 0x14[3:2]
// - positive wire fault code at 0x14[1:0]
// - fault pin low while any fault
// - control rates within 1Mbps / 400kbps
// - GPIO out bits 3,1, inputs 2,0
module dsr_top
  import dsr_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  // strap / dual-purpose pins
  input  wire logic        local_ctrl_chan_enable_i,
  input  wire logic        pin0_i,
  input  wire logic        pin1_i,
  input  wire logic        mode_pin_i,
  input  wire logic        rx_pin_i,
  input  wire logic        tx_pin_i,
  input  wire logic        i2c_mode_i,
  // internal register port from the control channel
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  // parallel data path
  input  wire logic [24:0] dout_i,
  output logic      [24:0] dout_o,
  output dsr_taps_t        stagger_taps_o,
  // configuration results
  output dsr_strap_t       strap_cfg_o,
  output logic             ctrl_chan_active_o,
  output logic             base_bypass_select_o,
  output logic             cc_rate_err_o,
  // open-drain GPIO, enable low while driving low
  output logic             pin0_out_level_o,
  output logic             pin0_oe_n_o,
  output logic             pin1_out_level_o,
  output logic             pin1_oe_n_o,
  // events
  input  wire logic        general_event_input_i,
  output logic             general_event_output_o,
  // line fault detector
  input  dsr_fault_t       fault_det_i,
  output logic             line_fault_n_o
);

  localparam int MIN_UART = `DSR_UART_MIN_CYC;
  localparam int MIN_I2C  = `DSR_I2C_MIN_CYC;

  dsr_state_t             state_q, state_d;
  dsr_strap_t             strap_q, strap_d;
  logic                   stag_dis_q, stag_dis_d;
  logic [1:0]             gout_q, gout_d;
  logic [1:0]             gin_q, gin_d;
  dsr_fault_t             fault_q, fault_d;
  logic                   lf_n_q, lf_n_d;
  logic [24:0]            dout_q, dout_d;
  dsr_taps_t              taps_q, taps_d;
  logic                   evt_q, evt_d;
  logic                   rx_q, rx_d;
  logic [`DSR_CNT_W-1:0]  gap_q, gap_d;
  logic                   rerr_q, rerr_d;
  logic [7:0]             rdata_q, rdata_d;
  logic                   wr_ok;

  // straps sampled on the first clock after reset release, then frozen
  always_comb begin
    state_d = state_q;
    strap_d = strap_q;
    unique case (state_q)
      DSR_ST_CAPTURE: begin
        strap_d.local_ctrl_chan_enable  = local_ctrl_chan_enable_i;
        strap_d.double_input_select     = pin0_i;
        strap_d.bus_width_select        = pin1_i;
        strap_d.sync_encoding_enable    = mode_pin_i;
        strap_d.error_correction_enable = rx_pin_i;
        strap_d.output_edge_select      = tx_pin_i;
        state_d = DSR_ST_RUN;
      end
      DSR_ST_RUN: begin
        state_d = DSR_ST_RUN; // later pin changes are ignored
      end
    endcase
  end

  // writes only arrive through the local channel, so strap mode blocks them
  assign wr_ok = reg_wr_i && (state_q == DSR_ST_RUN) && strap_q.local_ctrl_chan_enable;

  // register file next state
  always_comb begin
    stag_dis_d = stag_dis_q;
    gout_d     = gout_q;
    if (wr_ok && reg_addr_i == `DSR_ADDR_CFG) begin
      stag_dis_d = reg_wdata_i[`DSR_BIT_STAG_DIS];
    end
    if (wr_ok && reg_addr_i == `DSR_ADDR_GPIO) begin
      gout_d = {reg_wdata_i[`DSR_BIT_P1_OUT], reg_wdata_i[`DSR_BIT_P0_OUT]};
    end
    // fault register takes no write: nothing decodes that address here
    gin_d   = {pin1_i, pin0_i}; // input buffers always enabled
    fault_d = fault_det_i;      // live detector state
    lf_n_d  = (fault_det_i.neg_wire_fault_code == `DSR_LF_NORMAL) &&
              (fault_det_i.pos_wire_fault_code == `DSR_LF_NORMAL);
    rdata_d = 8'h00;
    unique case (reg_addr_i)
      `DSR_ADDR_CFG:   rdata_d[`DSR_BIT_STAG_DIS] = stag_dis_q;
      `DSR_ADDR_GPIO:  rdata_d[3:0] = {gout_q[1], gin_q[1], gout_q[0], gin_q[0]};
      `DSR_ADDR_FAULT: rdata_d[3:0] = {fault_q.neg_wire_fault_code,
                                       fault_q.pos_wire_fault_code};
      default:         rdata_d = 8'h00; // unmapped reads as zero
    endcase
  end

  // data path and stagger tap selection
  always_comb begin
    dout_d = dout_i;
    if (stag_dis_q) begin
      taps_d = '{`DSR_TAP_NONE, `DSR_TAP_NONE, `DSR_TAP_NONE, `DSR_TAP_NONE,
                 `DSR_TAP_NONE};
    end else begin
      taps_d = '{`DSR_TAP_G0, `DSR_TAP_G1, `DSR_TAP_G2, `DSR_TAP_G3, `DSR_TAP_CLK};
    end
  end

  // control channel rate monitor: transitions one bit time or less apart flag
  always_comb begin
    rx_d   = rx_pin_i;
    gap_d  = gap_q;
    rerr_d = rerr_q;
    evt_d  = general_event_input_i; // one cycle, far below 0.35 ms
    if (strap_q.local_ctrl_chan_enable && state_q == DSR_ST_RUN) begin
      if (rx_q != rx_pin_i) begin
        if (int'(gap_q) < (i2c_mode_i ? MIN_I2C : MIN_UART)) begin
          rerr_d = 1'b1; // sticky, host exceeded the supported rate
        end
        gap_d = '0;
      end else if (gap_q != {`DSR_CNT_W{1'b1}}) begin
        gap_d = gap_q + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_q    <= DSR_ST_CAPTURE;
      strap_q    <= '0;
      stag_dis_q <= 1'b0; // staggering on by default
      gout_q     <= `DSR_RST_GPIO_OUT;
      gin_q      <= 2'h0;
      fault_q    <= '{`DSR_LF_NORMAL, `DSR_LF_NORMAL};
      lf_n_q     <= 1'b1;
      dout_q     <= '0;
      taps_q     <= '0;
      evt_q      <= 1'b0;
      rx_q       <= 1'b1;
      gap_q      <= {`DSR_CNT_W{1'b1}};
      rerr_q     <= 1'b0;
      rdata_q    <= 8'h00;
    end else begin
      state_q    <= state_d;
      strap_q    <= strap_d;
      stag_dis_q <= stag_dis_d;
      gout_q     <= gout_d;
      gin_q      <= gin_d;
      fault_q    <= fault_d;
      lf_n_q     <= lf_n_d;
      dout_q     <= dout_d;
      taps_q     <= taps_d;
      evt_q      <= evt_d;
      rx_q       <= rx_d;
      gap_q      <= gap_d;
      rerr_q     <= rerr_d;
      rdata_q    <= rdata_d;
    end
  end

  // outputs; strap mode never drives the GPIO pins
  assign reg_rdata_o            = rdata_q;
  assign dout_o                 = dout_q;
  assign stagger_taps_o         = taps_q;
  assign strap_cfg_o            = strap_q;
  assign ctrl_chan_active_o     = strap_q.local_ctrl_chan_enable && (state_q == DSR_ST_RUN);
  assign base_bypass_select_o   = ctrl_chan_active_o & mode_pin_i;
  assign cc_rate_err_o          = rerr_q;
  assign pin0_out_level_o       = 1'b0;
  assign pin1_out_level_o       = 1'b0;
  assign pin0_oe_n_o            = ~(ctrl_chan_active_o & ~gout_q[0]);
  assign pin1_oe_n_o            = ~(ctrl_chan_active_o & ~gout_q[1]);
  assign general_event_output_o = evt_q;
  assign line_fault_n_o         = lf_n_q; // unfiltered, glitches reach the pin

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  // reset edge excluded: taps are cleared there although staggering is on
  property p_stag_taps;
    !stag_dis_q && !sys_rst_i |=> taps_q == dsr_taps_t'{`DSR_TAP_G0, `DSR_TAP_G1,
                                                       `DSR_TAP_G2, `DSR_TAP_G3,
                                                       `DSR_TAP_CLK};
  endproperty
  a_stag_taps: assert property (p_stag_taps) else $error("stagger taps wrong");

  property p_stag_off;
    stag_dis_q |=> taps_q == '0;
  endproperty
  a_stag_off: assert property (p_stag_off) else $error("taps not zero");

  property p_cfg_wr;
    wr_ok && reg_addr_i == `DSR_ADDR_CFG |=> stag_dis_q == $past(reg_wdata_i[`DSR_BIT_STAG_DIS]);
  endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("stagger disable not written");

  property p_no_cc;
    state_q == DSR_ST_RUN && !strap_q.local_ctrl_chan_enable |-> pin0_oe_n_o && pin1_oe_n_o;
  endproperty
  a_no_cc: assert property (p_no_cc) else $error("pins driven in strap mode");

  property p_strap_hold;
    state_q == DSR_ST_RUN |=> $stable(strap_q);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed");

  property p_lf_pin;
    fault_det_i != dsr_fault_t'{`DSR_LF_NORMAL, `DSR_LF_NORMAL} |=> !line_fault_n_o;
  endproperty
  a_lf_pin: assert property (p_lf_pin) else $error("fault pin not low");

  property p_lf_clear;
    fault_det_i == dsr_fault_t'{`DSR_LF_NORMAL, `DSR_LF_NORMAL} |=> line_fault_n_o;
  endproperty
  a_lf_clear: assert property (p_lf_clear) else $error("fault pin not released");

  property p_fault_rd;
    reg_addr_i == `DSR_ADDR_FAULT ##1 reg_addr_i == `DSR_ADDR_FAULT
      |=> reg_rdata_o[3:0] == $past(fault_det_i, 2);
  endproperty
  a_fault_rd: assert property (p_fault_rd) else $error("fault read mismatch");

  property p_gpio_drv;
    ctrl_chan_active_o && !gout_q[1] |-> !pin1_oe_n_o;
  endproperty
  a_gpio_drv: assert property (p_gpio_drv) else $error("gpio1 not pulled low");

  property p_evt;
    $rose(general_event_input_i) |=> general_event_output_o;
  endproperty
  a_evt: assert property (p_evt) else $error("event not forwarded");

endmodule : dsr_top

//--- verilog/dsr_defs.svh
`ifndef DSR_DEFS_SVH
`define DSR_DEFS_SVH

// register offsets on the internal register port
`define DSR_ADDR_CFG        8'h08
`define DSR_ADDR_GPIO       8'h0E
`define DSR_ADDR_FAULT      8'h14
// field positions
`define DSR_BIT_STAG_DIS    3
`define DSR_BIT_P1_OUT      3
`define DSR_BIT_P1_IN       2
`define DSR_BIT_P0_OUT      1
`define DSR_BIT_P0_IN       0
// reset values
`define DSR_RST_CFG         8'h00
`define DSR_RST_GPIO_OUT    2'h3
// line fault codes
`define DSR_LF_SUPPLY       2'h0
`define DSR_LF_GROUND       2'h1
`define DSR_LF_NORMAL       2'h2
`define DSR_LF_OPEN         2'h3
// stagger taps, unit 0.25 ns: 0, 0.5, 1, 1.5 and 0.75 ns
`define DSR_TAP_G0          3'h0
`define DSR_TAP_G1          3'h2
`define DSR_TAP_G2          3'h4
`define DSR_TAP_G3          3'h6
`define DSR_TAP_CLK         3'h3
`define DSR_TAP_NONE        3'h0
// timing
`define DSR_CLK_PERIOD_NS   20
`define DSR_UART_BIT_NS     1000
`define DSR_I2C_BIT_NS      2500
`define DSR_UART_MIN_CYC    ((`DSR_UART_BIT_NS + `DSR_CLK_PERIOD_NS - 1) / `DSR_CLK_PERIOD_NS)
`define DSR_I2C_MIN_CYC     ((`DSR_I2C_BIT_NS + `DSR_CLK_PERIOD_NS - 1) / `DSR_CLK_PERIOD_NS)
`define DSR_CNT_W           8

`endif

//--- verilog/dsr_pkg.sv
package dsr_pkg;
  // power-up sequencing
  typedef enum logic [0:0] {
    DSR_ST_CAPTURE = 1'b0,
    DSR_ST_RUN     = 1'b1
  } dsr_state_t;

  // latched strap configuration
  typedef struct packed {
    logic local_ctrl_chan_enable;
    logic double_input_select;
    logic bus_width_select;
    logic sync_encoding_enable;
    logic error_correction_enable;
    logic output_edge_select;
  } dsr_strap_t;

  // line fault detector codes
  typedef struct packed {
    logic [1:0] neg_wire_fault_code;
    logic [1:0] pos_wire_fault_code;
  } dsr_fault_t;

  // stagger tap settings per output group
  typedef struct packed {
    logic [2:0] grp0;
    logic [2:0] grp1;
    logic [2:0] grp2;
    logic [2:0] grp3;
    logic [2:0] pclk;
  } dsr_taps_t;
endpackage : dsr_pkg

//--- test/dsr_far_model.sv
`timescale 1ns/1ps
// far side stand-in: detector codes and a spaced event source
module dsr_far_model
  import dsr_pkg::*;
#(
  parameter int MIN_GAP = 17500
) (
  input  wire logic       clk_i,
  input  wire logic [3:0] code_i,
  input  wire logic       evt_req_i,
  output dsr_fault_t      fault_o,
  output logic            event_o
);
  int gap_q = MIN_GAP;
  initial event_o = 1'b0;
  // requests inside the spacing window are dropped, as a real sender must
  always @(posedge clk_i) begin
    fault_o <= code_i;
    if (gap_q < MIN_GAP) gap_q <= gap_q + 1;
    if (evt_req_i && gap_q >= MIN_GAP) begin // spacing
      event_o <= ~event_o;
      gap_q   <= 0;
    end
  end
endmodule : dsr_far_model

//--- test/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import dsr_pkg::*;
;
  logic        clk, rst, lcc, s0, s1, mode, rx, tx, i2c, wr, req;
  logic [7:0]  addr, wdata, rdata;
  logic [24:0] din, dout;
  logic [3:0]  code;
  dsr_taps_t   taps;
  dsr_strap_t  scfg;
  dsr_fault_t  flt;
  logic        cca, bbs, rerr, l0, oe0, l1, oe1, ev_i, ev_o, lfn;
  wire         p0 = oe0 ? s0 : 1'b0;
  wire         p1 = oe1 ? s1 : 1'b0;
  int          miscompares = 0;
  int          comparisons = 0;
  localparam logic [14:0] STAG = {3'h0, 3'h2, 3'h4, 3'h6, 3'h3};

  dsr_top uut (.ref_clk_i(clk), .sys_rst_i(rst), .local_ctrl_chan_enable_i(lcc),
    .pin0_i(p0), .pin1_i(p1), .mode_pin_i(mode), .rx_pin_i(rx), .tx_pin_i(tx),
    .i2c_mode_i(i2c), .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .dout_i(din), .dout_o(dout), .stagger_taps_o(taps),
    .strap_cfg_o(scfg), .ctrl_chan_active_o(cca), .base_bypass_select_o(bbs),
    .cc_rate_err_o(rerr), .pin0_out_level_o(l0), .pin0_oe_n_o(oe0),
    .pin1_out_level_o(l1), .pin1_oe_n_o(oe1), .general_event_input_i(ev_i),
    .general_event_output_o(ev_o), .fault_det_i(flt), .line_fault_n_o(lfn));
  dsr_far_model far (.clk_i(clk), .code_i(code), .evt_req_i(req), .fault_o(flt),
    .event_o(ev_i));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // pins are {lcc, pin0, pin1, mode, rx, tx}, valid before release
  task automatic do_reset(input logic [5:0] s);
    @(posedge clk);
    rst <= 1'b1;
    {lcc, s0, s1, mode, rx, tx} <= s;
    tick(20);
    rst <= 1'b0;
    tick(3);
    #1;
  endtask : do_reset

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    #1 chk(rdata, exp);
  endtask : reg_rd

  // straps latched once, held, writes blocked
  task automatic t_strap();
    logic [5:0] pat [2] = '{6'b010110, 6'b001001};
    foreach (pat[i]) begin
      do_reset(pat[i]);
      chk(scfg, pat[i]); // strap map
      chk({cca, bbs, oe0, oe1}, 4'b0011); // channel off, no bypass
      @(posedge clk);
      {s0, s1, mode, rx, tx} <= ~pat[i][4:0];
      reg_wr(8'h08, 8'h08);
      tick(3);
      chk(scfg, pat[i]); // held
      chk(taps, STAG); // still staggered
    end
    $display("test strap done");
  endtask : t_strap

  task automatic t_local();
    do_reset(6'b111011);
    chk({cca, taps}, {1'b1, STAG}); // local, default stagger
    reg_rd(8'h08, 8'h00); // default
    chk(bbs, 1'b0); // base mode while select low
    @(posedge clk);
    mode <= 1'b1;
    din  <= 25'h1ABCDEF;
    #1 chk(bbs, 1'b1); // bypass
    tick(2);
    #1 chk(dout, 25'h1ABCDEF); // parallel data carried through
    reg_wr(8'h08, 8'h08);
    tick(2);
    #1 chk(taps, 15'h0); // all zero
    reg_rd(8'h08, 8'h08); // bit 3
    chk(rerr, 1'b0); // rate ok
    // 60 cycles between edges: legal for the uart limit, too fast for i2c
    @(posedge clk);
    i2c <= 1'b0;
    rx  <= 1'b0;
    tick(60);
    rx  <= 1'b1; // host keeps within 1 Mbps
    tick(2);
    #1 chk(rerr, 1'b0); // spacing accepted at uart rate
    @(posedge clk);
    i2c <= 1'b1;
    tick(56);
    rx  <= 1'b0;
    tick(2);
    #1 chk(rerr, 1'b1); // too fast for 400 kbps
    $display("test local done");
  endtask : t_local

  task automatic t_gpio();
    reg_wr(8'h0E, 8'h00);
    tick(2);
    #1 chk({oe1, oe0, l1, l0}, 4'h0); // pulled low
    tick(3);
    reg_rd(8'h0E, 8'h00); // out and in bits
    @(posedge clk);
    s1 <= 1'b0;
    reg_wr(8'h0E, 8'h0A);
    tick(4);
    chk({oe1, oe0}, 2'b11); // released
    reg_rd(8'h0E, 8'h0B); // pin1 held low outside
    $display("test gpio done");
  endtask : t_gpio

  task automatic t_fault();
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      code <= 4'(i);
      tick(3); // host lets the pin settle before acting on it
      #1 chk(lfn, 1'(i == 10)); // low on any fault
      reg_rd(8'h14, 8'(i)); // fields
    end
    reg_wr(8'h14, 8'h0A);
    reg_rd(8'h14, 8'h0F); // read only, live
    $display("test fault done");
  endtask : t_fault

  task automatic t_event();
    chk(ev_o, 1'b0); // idle before any event
    @(posedge clk);
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    tick(4);
    #1 chk(ev_o, 1'b1); // forwarded
    // a second request inside the spacing window is held back by the sender
    @(posedge clk);
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    tick(4);
    #1 chk(ev_o, 1'b1); // no extra toggle
    $display("test event done");
  endtask : t_event

  initial begin
    {rst, lcc, s0, s1, mode, rx, tx, i2c, wr, req} = 10'h3FC;
    {addr, wdata, din, code} = {16'h0, 25'h0, 4'hA};
    t_strap();
    t_local();
    t_gpio();
    t_fault();
    t_event();
    stop_test();
  end

  // hang guard, well above the few hundred cycles the tests need
  initial begin
    tick(20000);
    miscompares++;
    stop_test();
  end
endmodule : tb_top
